// File: tb.sv
`timescale 1ns/10ps
module tb;
  import uart_tx_pkg::*;
  logic ref_clk, reset_n, reg_wr, reg_rd, tx_pin, tx_irq, nine;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, s;
  logic [1:0] par;
  logic [8:0] rx_data;
  logic rx_par;
  int rx_count, ferr_count, n_errors, cmp_count, cyc, irq_cnt, low_run, max_low, k, p, base;
  int exp_irq [4] = '{3, 1, 2, 3};

  uart_transmit_path i_uart_transmit_path (.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_pin(tx_pin),
    .tx_irq(tx_irq));
  uart_rx_model #(.BIT_CYC(4)) i_uart_rx_model (.ref_clk(ref_clk), .tx_pin(tx_pin), .nine(nine), .par(par),
    .rx_data(rx_data), .rx_par(rx_par), .rx_count(rx_count), .ferr_count(ferr_count));

  // ------------------------------
  // Clock, watchdog, line monitors
  // ------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      conclude();
    end
  end
  always @(negedge ref_clk) begin
    if (tx_irq === 1'b1) irq_cnt++;
    if (tx_pin === 1'b0) low_run++;
    else low_run = 0;
    if (low_run > max_low) max_low = low_run;
  end

  // ------------------------------
  // Bus tasks and checks
  // ------------------------------
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] expv);
    cmp_count++;
    if (seen !== expv) begin
      n_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, expv);
    end
  endtask
  // Polls status; the extra cycles let the receiver finish its stop bit
  task automatic wait_idle();
    int j;
    j = 0;
    s = 16'h0000;
    while (s[STAT_IDLE_BIT] !== 1'b1 && j < 4000) begin
      rd(STAT_ADDR, s);
      j++;
    end
    chk(16'(s[STAT_IDLE_BIT]), 16'h0001);
    repeat (12) @(posedge ref_clk);
  endtask
  task automatic conclude();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ------------------------------
  // Scenarios
  // ------------------------------
  initial begin
    {reset_n, reg_wr, reg_rd, nine, par, reg_addr, reg_wdata} <= '0;
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    #1 chk(16'(tx_pin), 16'h0001);
    rd(STAT_ADDR, s);
    chk(s, 16'h0006);
    rd(BRG_ADDR, s);
    chk(s, BRG_RESET);
    rd(3'h7, s);
    chk(s, 16'h0000);
    wr(MODE_ADDR, 16'h0000);
    wr(BRG_ADDR, 16'h0003);
    rd(BRG_ADDR, s);
    chk(s, 16'h0003);
    wr(CTRL_ADDR, 16'h0000);
    wr(MODE_ADDR, 16'h0001);
    wr(DATA_ADDR, 16'h00A5);
    repeat (20) @(posedge ref_clk);
    #1 chk(16'(tx_pin), 16'h0001);
    wr(CTRL_ADDR, 16'h0001);
    @(posedge ref_clk);
    #1 chk(16'(tx_irq), 16'h0000);
    chk(16'(tx_pin), 16'h0000);
    @(posedge ref_clk);
    #1 chk(16'(tx_irq), 16'h0001);
    @(posedge ref_clk);
    #1 chk(16'(tx_irq), 16'h0000);
    wait_idle();
    chk(16'(rx_data), 16'h00A5);
    for (p = 0; p < 4; p++) begin
      par = 2'(p);
      wr(MODE_ADDR, 16'(1 | (p << 2) | ((p & 1) << 4)));
      wr(DATA_ADDR, 16'(8'h3C ^ p));
      k = 0;
      while (tx_pin !== 1'b0 && k < 20) begin
        @(posedge ref_clk);
        #1 k++;
      end
      chk(16'(k >= 2 && k <= 5), 16'h0001);
      wait_idle();
      chk(16'(rx_data), 16'(8'h3C ^ p));
      if (p == 1 || p == 2) chk(16'(rx_par), 16'((^(8'h3C ^ p)) ^ (p == 2)));
    end
    par = 2'h0;
    nine = 1'b1;
    wr(MODE_ADDR, 16'h0003);
    wr(DATA_ADDR, 16'h01A5);
    wait_idle();
    chk(16'(rx_data), 16'h01A5);
    nine = 1'b0;
    wr(MODE_ADDR, 16'h0001);
    for (p = 0; p < 4; p++) begin
      wr(CTRL_ADDR, 16'(1 | (p << 2)));
      irq_cnt = 0;
      for (k = 0; k < 3; k++) wr(DATA_ADDR, 16'(k));
      wait_idle();
      chk(16'(irq_cnt), 16'(exp_irq[p]));
    end
    // Transmitter held off; the shifter takes the first word, then the queue can only fill
    wr(CTRL_ADDR, 16'h0000);
    for (k = 0; k < 34; k++) wr(DATA_ADDR, 16'(k));
    rd(STAT_ADDR, s);
    chk(s, 16'h0001);
    base = rx_count;
    wr(CTRL_ADDR, 16'h0001);
    wait_idle();
    chk(16'(rx_count - base), 16'h0021);
    chk(16'(rx_data), 16'h0020);
    max_low = 0;
    base = ferr_count;
    wr(CTRL_ADDR, 16'h0003);
    wr(DATA_ADDR, 16'h00FF);
    wr(DATA_ADDR, 16'h0055);
    wait_idle();
    chk(16'(max_low), 16'(BRK_LOW_BITS * 4));
    chk(16'(ferr_count - base), 16'h0001);
    chk(16'(rx_data), 16'h0055);
    rd(CTRL_ADDR, s);
    chk(16'(s[CTRL_BRK_BIT]), 16'h0000);
    wr(3'h7, 16'hFFFF);
    rd(STAT_ADDR, s);
    chk(s, 16'h0006);
    conclude();
  end
endmodule // tb

// File: uart_rx_model.sv
`timescale 1ns/10ps
module uart_rx_model #(
  parameter int BIT_CYC = 4
) (
  input wire logic ref_clk,
  input wire logic tx_pin,
  input wire logic nine,
  input wire logic [1:0] par,
  output logic [8:0] rx_data,
  output logic rx_par,
  output int rx_count,
  output int ferr_count
);
  // ------------------------------
  // Mid-bit sampler
  // ------------------------------
  // Samples on the falling clock, away from the edge where tx_pin moves
  int i;
  initial begin
    rx_data = 9'h000;
    rx_par = 1'b0;
    rx_count = 0;
    ferr_count = 0;
    forever begin
      @(negedge tx_pin);
      repeat (BIT_CYC / 2) @(negedge ref_clk);
      if (tx_pin === 1'b0) begin
        rx_data = 9'h000;
        for (i = 0; i < (nine ? 9 : 8); i++) begin
          repeat (BIT_CYC) @(negedge ref_clk);
          rx_data[i] = tx_pin;
        end
        if (par == 2'h1 || par == 2'h2) begin
          repeat (BIT_CYC) @(negedge ref_clk);
          rx_par = tx_pin;
        end
        repeat (BIT_CYC) @(negedge ref_clk);
        if (tx_pin !== 1'b1) ferr_count++;
        rx_count++;
      end
    end
  end
endmodule // uart_rx_model

// File: uart_transmit_path.sv
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/10ps
module uart_transmit_path
  import uart_tx_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  output logic tx_pin,
  output logic tx_irq
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  typedef enum logic {ST_IDLE, ST_SHIFT} state_t;

  mode_t mode_q;
  logic ten_q, brk_q, brk_armed_q, brk_frame_q, first_q, tx_q, ten_prev_q, tx_irq_q;
  irq_sel_t sel_q;
  logic [15:0] brg_q, baud_cnt_q;
  state_t state_q;
  logic [FRAME_W-1:0] sr_q;
  logic [4:0] cnt_q;
  logic [IRQ_DELAY_CYCLES-2:0] rise_dly_q;
  logic [DATA_W-1:0] rdata_q;

  tx_word_t wr_word, fifo_word;
  logic fifo_in_ready, fifo_out_valid, push_req, pop, tick, done_ev, irq_ev;
  logic [$clog2(DEPTH):0] fifo_count;
  frame_t frame;

  function automatic frame_t build_frame(input mode_t m, input tx_word_t w);
    frame_t f;
    logic par;
    int dn;
    f.bits = '1;
    dn = m.nine_bit ? 9 : 8;
    par = m.nine_bit ? ^w.data : ^w.data[7:0];
    if (m.parity == PAR_ODD) begin
      par = ~par;
    end
    f.bits[0] = 1'b0;
    for (int i = 0; i < 9; i++) begin
      if (i < dn) begin
        f.bits[i+1] = w.data[i];
      end
    end
    if (m.parity == PAR_EVEN || m.parity == PAR_ODD) begin
      f.bits[dn+1] = par;
      dn = dn + 1;
    end
    f.len = 5'(1 + dn + (m.stop2 ? 2 : 1));
    if (w.brk) begin
      f.bits = '1;
      f.bits[BRK_LOW_BITS-1:0] = '0;
      f.len = 5'(BRK_LOW_BITS + 1);
    end
    return f;
  endfunction

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_q <= '0;
      brg_q <= BRG_RESET;
    end else if (reg_wr && reg_addr == MODE_ADDR) begin
      mode_q <= mode_t'(reg_wdata[MODE_STOP2_BIT:MODE_EN_BIT]);
    end else if (reg_wr && reg_addr == BRG_ADDR) begin
      brg_q <= reg_wdata;
    end
  end

  // Software write wins over the hardware clear of the break bit
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ten_q <= 1'b0;
      brk_q <= 1'b0;
      sel_q <= SEL_SPACE;
    end else if (reg_wr && reg_addr == CTRL_ADDR) begin
      ten_q <= reg_wdata[CTRL_TEN_BIT];
      brk_q <= reg_wdata[CTRL_BRK_BIT];
      sel_q <= irq_sel_t'(reg_wdata[CTRL_SEL_LSB+:2]);
    end else if (done_ev && brk_frame_q) begin
      brk_q <= 1'b0;
    end
  end

  // Only the first character after arming becomes the break
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      brk_armed_q <= 1'b0;
    end else if (reg_wr && reg_addr == CTRL_ADDR) begin
      brk_armed_q <= reg_wdata[CTRL_BRK_BIT] && !brk_q;
    end else if (push_req && fifo_in_ready) begin
      brk_armed_q <= 1'b0;
    end
  end

  // Writes to a full queue are dropped; status shows full
  assign push_req = reg_wr && reg_addr == DATA_ADDR;
  assign wr_word.brk = brk_armed_q;
  assign wr_word.data = reg_wdata[8:0];

  uart_tx_fifo #(
    .WIDTH($bits(tx_word_t)),
    .DEPTH(DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .in_data(wr_word),
    .in_valid(push_req),
    .in_ready(fifo_in_ready),
    .out_data(fifo_word),
    .out_valid(fifo_out_valid),
    .out_ready(pop),
    .count(fifo_count)
  );

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        MODE_ADDR: rdata_q <= DATA_W'(mode_q);
        CTRL_ADDR: rdata_q <= DATA_W'({sel_q, brk_q, ten_q});
        BRG_ADDR: rdata_q <= brg_q;
        STAT_ADDR: rdata_q <= DATA_W'({!fifo_out_valid, state_q == ST_IDLE && !fifo_out_valid, !fifo_in_ready});
        default: rdata_q <= '0;
      endcase
    end else begin
      rdata_q <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Baud clock
  // ----------------------------------------------------------------
  // Held cleared while disabled, so the first enabled cycle ticks
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      baud_cnt_q <= '0;
    end else if (!ten_q || !mode_q.port_en) begin
      baud_cnt_q <= '0;
    end else if (baud_cnt_q == '0) begin
      baud_cnt_q <= brg_q;
    end else begin
      baud_cnt_q <= baud_cnt_q - 1'b1;
    end
  end

  assign tick = ten_q && mode_q.port_en && baud_cnt_q == '0;

  // ----------------------------------------------------------------
  // Shift register
  // ----------------------------------------------------------------
  assign pop = mode_q.port_en && state_q == ST_IDLE && fifo_out_valid;
  assign frame = build_frame(mode_q, fifo_word);
  assign done_ev = state_q == ST_SHIFT && tick && cnt_q == '0;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      sr_q <= '1;
      cnt_q <= '0;
      brk_frame_q <= 1'b0;
      first_q <= 1'b0;
      tx_q <= 1'b1;
    end else if (!mode_q.port_en) begin
      state_q <= ST_IDLE;
      first_q <= 1'b0;
      tx_q <= 1'b1;
    end else begin
      case (state_q)
        ST_IDLE: begin
          tx_q <= 1'b1;
          if (pop) begin
            state_q <= ST_SHIFT;
            sr_q <= frame.bits;
            cnt_q <= frame.len;
            brk_frame_q <= fifo_word.brk;
            first_q <= 1'b1;
          end
        end
        ST_SHIFT: begin
          if (tick) begin
            first_q <= 1'b0;
            if (cnt_q != '0) begin
              tx_q <= sr_q[0];
              sr_q <= {1'b1, sr_q[FRAME_W-1:1]};
              cnt_q <= cnt_q - 1'b1;
            end else begin
              state_q <= ST_IDLE;
              tx_q <= 1'b1;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Transmit interrupt
  // ----------------------------------------------------------------
  always_comb begin
    case (sel_q)
      SEL_DONE: irq_ev = done_ev && !fifo_out_valid;
      SEL_EMPTY: irq_ev = pop && fifo_count == 1;
      default: irq_ev = pop;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ten_prev_q <= 1'b0;
      rise_dly_q <= '0;
      tx_irq_q <= 1'b0;
    end else begin
      ten_prev_q <= ten_q;
      rise_dly_q <= (IRQ_DELAY_CYCLES-1)'({rise_dly_q, ten_q && !ten_prev_q});
      tx_irq_q <= rise_dly_q[IRQ_DELAY_CYCLES-2] || irq_ev;
    end
  end

  assign tx_pin = tx_q;
  assign tx_irq = tx_irq_q;
  assign reg_rdata = rdata_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  property p_en_irq;
    $rose(ten_q) |-> ##2 tx_irq;
  endproperty
  a_en_irq: assert property (p_en_irq) else $error("No interrupt two cycles after enable");
  property p_load8;
    (pop && !mode_q.nine_bit && !fifo_word.brk) |=> (state_q == ST_SHIFT && sr_q[8:1] == $past(fifo_word.data[7:0]));
  endproperty
  a_load8: assert property (p_load8) else $error("Byte not loaded into shifter");
  property p_start_now;
    $rose(ten_q) && mode_q.port_en |-> tick;
  endproperty
  a_start_now: assert property (p_start_now) else $error("Baud clock not started cleared");
  property p_sel_done;
    (tx_irq && $past(sel_q) == SEL_DONE && !$past(rise_dly_q[IRQ_DELAY_CYCLES-2])) |-> $past(done_ev) && state_q == ST_IDLE;
  endproperty
  a_sel_done: assert property (p_sel_done) else $error("Completion interrupt without completion");
  property p_load9;
    (pop && mode_q.nine_bit && !fifo_word.brk) |=> sr_q[9:1] == $past(fifo_word.data);
  endproperty
  a_load9: assert property (p_load9) else $error("Nine bits not loaded");
  property p_brk_clear;
    $fell(brk_q) && !$past(reg_wr && reg_addr == CTRL_ADDR) |-> $past(done_ev && brk_frame_q);
  endproperty
  a_brk_clear: assert property (p_brk_clear) else $error("Break bit cleared early");
  property p_brk_low;
    (first_q && tick && brk_frame_q) |=> !tx_pin [*8];
  endproperty
  a_brk_low: assert property (p_brk_low) else $error("Break line not held low");
  property p_start_bit;
    (first_q && tick) |=> !tx_pin;
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("Frame did not open with low start");
  property p_idle_high;
    state_q == ST_IDLE |-> tx_pin;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("Line not high while idle");
  c_frame: cover property (pop ##[1:100] done_ev);
  c_break: cover property (done_ev && brk_frame_q);
  c_full: cover property (push_req && !fifo_in_ready);

endmodule // uart_transmit_path

// File: uart_tx_fifo.sv
`timescale 1ns/10ps
module uart_tx_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 32
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic push;
  logic pop;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_q <= '0;
      rd_q <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // uart_tx_fifo

// File: uart_tx_pkg.sv
package uart_tx_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 3;
  localparam logic [ADDR_W-1:0] MODE_ADDR = 3'h0;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 3'h1;
  localparam logic [ADDR_W-1:0] DATA_ADDR = 3'h2;
  localparam logic [ADDR_W-1:0] BRG_ADDR = 3'h3;
  localparam logic [ADDR_W-1:0] STAT_ADDR = 3'h4;
  localparam int DATA_W = 16;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MODE_EN_BIT = 0;
  localparam int MODE_NINE_BIT = 1;
  localparam int MODE_PAR_LSB = 2;
  localparam int MODE_STOP2_BIT = 4;
  localparam int CTRL_TEN_BIT = 0;
  localparam int CTRL_BRK_BIT = 1;
  localparam int CTRL_SEL_LSB = 2;
  localparam int STAT_FULL_BIT = 0;
  localparam int STAT_IDLE_BIT = 1;
  localparam int STAT_EMPTY_BIT = 2;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [15:0] BRG_RESET = 16'h0000;
  localparam int IRQ_DELAY_CYCLES = 2;
  localparam int BRK_LOW_BITS = 13;
  localparam int FIFO_DEPTH = 32;
  localparam int FRAME_W = 16;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {PAR_NONE, PAR_EVEN, PAR_ODD, PAR_RSVD} parity_t;
  typedef enum logic [1:0] {SEL_SPACE, SEL_DONE, SEL_EMPTY, SEL_RSVD} irq_sel_t;

  typedef struct packed {
    logic stop2;
    parity_t parity;
    logic nine_bit;
    logic port_en;
  } mode_t;

  typedef struct packed {
    logic brk;
    logic [8:0] data;
  } tx_word_t;

  typedef struct packed {
    logic [4:0] len;
    logic [FRAME_W-1:0] bits;
  } frame_t;

endpackage
